// ---- cfas_consts.svh ----
// Purpose: Constants for the carry flag arithmetic and skip block.
// Assumes: One clock domain; opcodes arrive one per request.
// Notes: Opcode values, field widths and program counter steps.
// What this block does
// - Add with carry sums memory, accumulator and flag to 8 bits; flag gets the carry out.
// - Only shift, add and subtract instructions may change the carry flag; others keep it.
// - Opcodes 74 and 7C add in the carry flag, while F4 and FC ignore it.
// - After every add opcode the carry flag shows whether bit 7 carried out.
// - Subtraction inverts the subtrahend and adds it plus one to the minuend.
// - Opcodes 75, 7D, 77 and 7F take the carry flag as borrow-in, where 0 takes one off.
// - Opcodes F5, FD, F7 and FF ignore the carry flag held before them.
// - After every subtract opcode the flag is 1 for no borrow and 0 for a borrow.
// - The reverse subtract leaves memory byte minus accumulator in the accumulator.
// - The reverse subtract with borrow adds the flag as carry-in and sets it on no borrow.
// - Opcode 38 steps over the one byte after it.
// - The never-taken short branch is the same opcode 38 and never loads its target.
// - Opcode C8 steps over the two bytes after it.
// - The never-taken long branch shares opcode C8 and never takes its address.
// - The long skip on carry steps over two bytes when the flag is 1, else falls through.
// - The plain add keeps an 8-bit sum and sets the flag on a carry out of bit 7.
`ifndef CFAS_CONSTS_SVH
`define CFAS_CONSTS_SVH
`define CFAS_DATA_W      8
`define CFAS_PC_W        16
`define CFAS_OP_ADD      8'hf4
`define CFAS_OP_ADDI     8'hfc
`define CFAS_OP_ADC      8'h74
`define CFAS_OP_ADCI     8'h7c
`define CFAS_OP_RSUB     8'hf5
`define CFAS_OP_RSUBI    8'hfd
`define CFAS_OP_RSUBB    8'h75
`define CFAS_OP_RSUBBI   8'h7d
`define CFAS_OP_SUBM     8'hf7
`define CFAS_OP_SUBMI    8'hff
`define CFAS_OP_SUBMB    8'h77
`define CFAS_OP_SUBMBI   8'h7f
`define CFAS_OP_SKIP1    8'h38
`define CFAS_OP_SKIP2    8'hc8
`define CFAS_OP_SKIPC    8'hcf
`define CFAS_STEP_ONE    16'h0001
`define CFAS_STEP_IMM    16'h0002
`define CFAS_STEP_SKIP2  16'h0003
`define CFAS_ACC_RST     8'h00
`define CFAS_PC_RST      16'h0000
`endif

// ---- cfas_pkg.sv ----
// Purpose: Types shared by the carry flag arithmetic and skip block.
// Assumes: Constants come from cfas_consts.svh.
// Notes: Operation classes and the registered state of the block.
package cfas_pkg;
    // Operation class decoded from an opcode.
    typedef enum logic [2:0] {
        CFAS_ADD,
        CFAS_RSUB,
        CFAS_SUBM,
        CFAS_SKIP1,
        CFAS_SKIP2,
        CFAS_SKIPC,
        CFAS_OTHER
    } cfas_class_t;

    // Whole registered state of the block.
    typedef struct packed {
        logic [7:0]  acc;
        logic        carry_flag;
        logic [15:0] pc;
        logic        done;
    } cfas_state_t;
endpackage : cfas_pkg

// ---- cfas_core.sv ----
// Purpose: Carry flag add and subtract datapath with skip handling.
// Assumes: One opcode per request; the operand byte is valid with it.
// Notes: Results and the new program counter appear one cycle later.
`include "cfas_consts.svh"
`timescale 1ns/1ps
module cfas_core (
    // Clock and reset.
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rstn,
    // Instruction request.
    input  wire logic                    i_valid,
    input  wire logic [`CFAS_DATA_W-1:0] i_opcode,
    input  wire logic [`CFAS_DATA_W-1:0] i_mem_data,
    // Loads from the rest of the processor.
    input  wire logic                    i_acc_load,
    input  wire logic [`CFAS_DATA_W-1:0] i_acc_value,
    input  wire logic                    i_pc_load,
    input  wire logic [`CFAS_PC_W-1:0]   i_pc_value,
    // Results.
    output logic      [`CFAS_DATA_W-1:0] o_acc,
    output logic                         o_carry_flag,
    output logic      [`CFAS_PC_W-1:0]   o_pc,
    output logic                         o_done
);
    cfas_pkg::cfas_state_t state_ff;
    cfas_pkg::cfas_state_t nxt_state;

    // Maps an opcode onto its operation class.
    function automatic cfas_pkg::cfas_class_t op_class(input logic [7:0] op);
        case (op)
            `CFAS_OP_ADD, `CFAS_OP_ADDI, `CFAS_OP_ADC, `CFAS_OP_ADCI: begin
                op_class = cfas_pkg::CFAS_ADD;
            end
            `CFAS_OP_RSUB, `CFAS_OP_RSUBI, `CFAS_OP_RSUBB, `CFAS_OP_RSUBBI: begin
                op_class = cfas_pkg::CFAS_RSUB;
            end
            `CFAS_OP_SUBM, `CFAS_OP_SUBMI, `CFAS_OP_SUBMB, `CFAS_OP_SUBMBI: begin
                op_class = cfas_pkg::CFAS_SUBM;
            end
            `CFAS_OP_SKIP1: op_class = cfas_pkg::CFAS_SKIP1;
            `CFAS_OP_SKIP2: op_class = cfas_pkg::CFAS_SKIP2;
            `CFAS_OP_SKIPC: op_class = cfas_pkg::CFAS_SKIPC;
            default:        op_class = cfas_pkg::CFAS_OTHER;
        endcase
    endfunction : op_class

    // Nine-bit sum of two bytes and a carry-in; bit 8 is the carry out.
    function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction : add9

    cfas_pkg::cfas_class_t cls;
    logic                  uses_flag;
    logic                  is_imm;
    logic [8:0]            sum;

    // Bit 3 of the opcode marks the immediate forms; bit 7 low means the flag feeds in.
    assign cls       = op_class(i_opcode);
    assign uses_flag = ~i_opcode[7];
    assign is_imm    = i_opcode[3];

    // Datapath: subtracts invert the subtrahend and add one, or the flag when chained.
    always_comb begin
        case (cls)
            cfas_pkg::CFAS_ADD: begin
                sum = add9(state_ff.acc, i_mem_data,
                           uses_flag & state_ff.carry_flag);
            end
            cfas_pkg::CFAS_RSUB: begin
                sum = add9(i_mem_data, ~state_ff.acc,
                           uses_flag ? state_ff.carry_flag : 1'b1);
            end
            cfas_pkg::CFAS_SUBM: begin
                sum = add9(state_ff.acc, ~i_mem_data,
                           uses_flag ? state_ff.carry_flag : 1'b1);
            end
            default: sum = 9'h000;
        endcase
    end

    // Next state; only arithmetic touches the flag, and only arithmetic or an accumulator load the accumulator.
    always_comb begin
        nxt_state      = state_ff;
        nxt_state.done = 1'b0;
        if (i_acc_load) begin
            nxt_state.acc = i_acc_value;
        end
        if (i_pc_load) begin
            nxt_state.pc = i_pc_value;
        end
        if (i_valid) begin
            nxt_state.done = 1'b1;
            case (cls)
                cfas_pkg::CFAS_ADD, cfas_pkg::CFAS_RSUB, cfas_pkg::CFAS_SUBM: begin
                    nxt_state.acc        = sum[7:0];
                    nxt_state.carry_flag = sum[8];
                    nxt_state.pc = state_ff.pc + (is_imm ? `CFAS_STEP_IMM : `CFAS_STEP_ONE);
                end
                cfas_pkg::CFAS_SKIP1: begin
                    nxt_state.pc = state_ff.pc + `CFAS_STEP_IMM;
                end
                cfas_pkg::CFAS_SKIP2: begin
                    nxt_state.pc = state_ff.pc + `CFAS_STEP_SKIP2;
                end
                cfas_pkg::CFAS_SKIPC: begin
                    nxt_state.pc = state_ff.pc + (state_ff.carry_flag ?
                                   `CFAS_STEP_SKIP2 : `CFAS_STEP_ONE);
                end
                default: begin
                    // Flag and accumulator held
                    nxt_state.pc = state_ff.pc + `CFAS_STEP_ONE;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= '{acc: `CFAS_ACC_RST, carry_flag: 1'b0, pc: `CFAS_PC_RST, done: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register.
    assign o_acc        = state_ff.acc;
    assign o_carry_flag = state_ff.carry_flag;
    assign o_pc         = state_ff.pc;
    assign o_done       = state_ff.done;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // Request on an arithmetic opcode of the given kind.
    sequence s_add_req;
        i_valid && !i_acc_load && i_opcode inside {8'h74, 8'h7c, 8'hf4, 8'hfc};
    endsequence

    // Request on a skip opcode; none of them may touch the accumulator or the flag.
    sequence s_skip_req;
        i_valid && !i_acc_load && i_opcode inside {8'h38, 8'hc8, 8'hcf};
    endsequence

    // Request on a subtract that takes the memory byte from the accumulator.
    sequence s_subm_req;
        i_valid && !i_acc_load && i_opcode inside {8'hf7, 8'hff, 8'h77, 8'h7f};
    endsequence

    // Arithmetic results are checked one cycle after the request edge; a load in
    // the same cycle loses to the arithmetic, so those cycles are left out here.
    add_chained_a: assert property (s_add_req and i_opcode[7] == 1'b0 |=>
        {o_carry_flag, o_acc} == $past({1'b0, state_ff.acc}) + $past({1'b0, i_mem_data})
            + $past({8'h00, state_ff.carry_flag}))
        else $error("Chained add result or carry wrong.");
    add_plain_a: assert property (s_add_req and i_opcode[7] == 1'b1 |=>
        {o_carry_flag, o_acc} == $past({1'b0, state_ff.acc}) + $past({1'b0, i_mem_data}))
        else $error("Plain add result or carry wrong.");
    rsub_plain_a: assert property (i_valid && !i_acc_load &&
        i_opcode inside {8'hf5, 8'hfd} |=> o_acc == $past(i_mem_data - state_ff.acc)
        && o_carry_flag == ($past(i_mem_data) >= $past(state_ff.acc)))
        else $error("Reverse subtract wrong.");
    subm_borrow_a: assert property (i_valid && !i_acc_load &&
        i_opcode inside {8'h77, 8'h7f} |=> o_acc == $past(state_ff.acc - i_mem_data
        - {7'h00, ~state_ff.carry_flag}))
        else $error("Subtract with borrow result wrong.");
    flag_held_a: assert property (i_valid && cls == cfas_pkg::CFAS_OTHER |=>
        $stable(o_carry_flag))
        else $error("Flag changed by a non-arithmetic opcode.");
    skip_short_a: assert property (i_valid && !i_pc_load && i_opcode == 8'h38 |=>
        o_pc == $past(state_ff.pc) + 16'h0002 && $stable(o_carry_flag))
        else $error("Short skip step wrong.");
    skip_long_a: assert property (i_valid && !i_pc_load && !i_acc_load &&
        i_opcode == 8'hc8 |=> o_pc == $past(state_ff.pc) + 16'h0003 && $stable(o_acc))
        else $error("Long skip step wrong.");
    skip_carry_a: assert property (i_valid && !i_pc_load && i_opcode == 8'hcf |=>
        o_pc == $past(state_ff.pc) + ($past(state_ff.carry_flag) ? 16'h0003 : 16'h0001))
        else $error("Carry skip step wrong.");
    done_pulse_a: assert property (i_valid |=> o_done ##1 (o_done == $past(i_valid)))
        else $error("Done pulse not tied to request.");

    // Every add leaves the carry out of bit 7 in the flag, whatever the old flag was.
    add_flag_a: assert property (s_add_req |=>
        o_carry_flag == (({1'b0, $past(state_ff.acc)} + {1'b0, $past(i_mem_data)}
            + {8'h00, $past(state_ff.carry_flag & ~i_opcode[7])}) > 9'h0ff))
        else $error("Add carry flag wrong.");

    // Plain reverse subtract is the memory byte plus the inverted accumulator plus one.
    rsub_twos_a: assert property (i_valid && !i_acc_load &&
        i_opcode inside {8'hf5, 8'hfd} |=> {o_carry_flag, o_acc} ==
            $past({1'b0, i_mem_data}) + $past({1'b0, ~state_ff.acc}) + 9'h001)
        else $error("Two's complement subtract wrong.");

    // Chained reverse subtract takes the flag as its carry-in.
    rsub_borrow_a: assert property (i_valid && !i_acc_load &&
        i_opcode inside {8'h75, 8'h7d} |=> {o_carry_flag, o_acc} ==
            $past({1'b0, i_mem_data}) + $past({1'b0, ~state_ff.acc})
            + $past({8'h00, state_ff.carry_flag}))
        else $error("Reverse subtract with borrow wrong.");

    // Plain forward subtract ignores the old flag entirely.
    subm_plain_a: assert property (s_subm_req and i_opcode[7] == 1'b1 |=>
        o_acc == $past(state_ff.acc - i_mem_data)
        && o_carry_flag == ($past(state_ff.acc) >= $past(i_mem_data)))
        else $error("Plain subtract wrong.");

    // With borrow-in, no borrow only when the minuend covers operand and pending borrow.
    subm_flag_a: assert property (s_subm_req and i_opcode[7] == 1'b0 |=>
        o_carry_flag == ({1'b0, $past(state_ff.acc)}
            >= {1'b0, $past(i_mem_data)} + {8'h00, ~$past(state_ff.carry_flag)}))
        else $error("Subtract with borrow flag wrong.");

    // Skipped bytes only move the counter.
    skip_keeps_a: assert property (s_skip_req |=>
        $stable(o_acc) && $stable(o_carry_flag))
        else $error("Skip changed the accumulator or flag.");

    // An accumulator load is not arithmetic, so the flag must hold across it.
    load_flag_a: assert property (i_acc_load && !i_valid |=>
        o_acc == $past(i_acc_value) && $stable(o_carry_flag))
        else $error("Accumulator load wrong or flag disturbed.");
endmodule : cfas_core

// ---- cfas_prog_mem.sv ----
// Purpose: Program memory model feeding opcode and operand bytes.
// Assumes: Reads are combinational from the byte address.
// Notes: The bench fills the array before each request is raised.
`timescale 1ns/1ps
module cfas_prog_mem (
    // Fetch address.
    input  wire logic [7:0] i_addr,
    // Opcode byte and the byte that follows it.
    output logic      [7:0] o_op,
    output logic      [7:0] o_arg
);
    logic [7:0] mem [0:255];
    // Both bytes come at once, so one request carries the whole instruction.
    assign o_op  = mem[i_addr];
    assign o_arg = mem[i_addr + 8'h01];
endmodule : cfas_prog_mem

// ---- carry_flag_arith_and_skip_test.sv ----
// Purpose: Self-checking bench for the carry flag arithmetic and skip block.
// Assumes: Results land one cycle after the request edge.
// Notes: Expected state is kept in a small model of acc, flag and pc.
`timescale 1ns/1ps
module carry_flag_arith_and_skip_test;
    logic        clk = 1'b0, rstn = 1'b0, vld = 1'b0, a_ld = 1'b0, p_ld = 1'b0;
    logic [7:0]  a_val = 8'h00, addr = 8'h00, acc_m = 8'h00, ptr = 8'h00;
    logic [15:0] p_val = 16'h0000, pc_m = 16'h0000;
    logic        cf_m = 1'b0;
    logic [7:0]  op, arg, acc;
    logic [15:0] pc;
    logic        cf, done;
    int          bad_count = 0, total_checks = 0;
    // Clock at 200 MHz.
    initial forever #2.5 clk = ~clk;
    cfas_prog_mem pm (.i_addr(addr), .o_op(op), .o_arg(arg));
    cfas_core dut (.i_ref_clk(clk), .i_rstn(rstn), .i_valid(vld), .i_opcode(op),
        .i_mem_data(arg), .i_acc_load(a_ld), .i_acc_value(a_val), .i_pc_load(p_ld),
        .i_pc_value(p_val), .o_acc(acc), .o_carry_flag(cf), .o_pc(pc), .o_done(done));
    // Compares done, acc, flag and pc in one go.
    task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // Loads are held for exactly one edge, then released on the next.
    task automatic load(input logic is_pc, input logic [15:0] v);
        @(posedge clk);
        if (is_pc) begin p_ld <= 1'b1; p_val <= v; pc_m = v; end
        else begin a_ld <= 1'b1; a_val <= v[7:0]; acc_m = v[7:0]; end
        @(posedge clk);
        p_ld <= 1'b0;
        a_ld <= 1'b0;
        #1 chk({done, acc, cf, pc}, {1'b0, acc_m, cf_m, pc_m});
    endtask : load
    // One instruction through the partner; the model works out the outcome.
    task automatic run(input logic [7:0] o, input logic [7:0] m);
        logic [8:0] s;
        logic       ar, ci;
        pm.mem[ptr] = o;
        pm.mem[ptr + 8'h01] = m;
        @(posedge clk);
        vld <= 1'b1;
        addr <= ptr;
        ptr = ptr + 8'h02;
        @(posedge clk);
        vld <= 1'b0;
        ar = (o[7:4] == 4'h7 || o[7:4] == 4'hf) && (o[3:0] inside {4'h4, 4'hc, 4'h5, 4'hd,
            4'h7, 4'hf});
        ci = o[7] ? o[0] : cf_m;
        if (!ar) s = {cf_m, acc_m};
        else if (o[1:0] == 2'b00) s = {1'b0, m} + {1'b0, acc_m} + ci;
        else if (o[1] == 1'b0) s = {1'b0, m} + {1'b0, ~acc_m} + ci;
        else s = {1'b0, acc_m} + {1'b0, ~m} + ci;
        if (o == 8'h38) pc_m = pc_m + 16'h0002;
        else if (o == 8'hc8 || (o == 8'hcf && cf_m)) pc_m = pc_m + 16'h0003;
        else pc_m = pc_m + ((ar && o[3]) ? 16'h0002 : 16'h0001);
        {cf_m, acc_m} = s;
        #1 chk({done, acc, cf, pc}, {1'b1, acc_m, cf_m, pc_m});
        @(posedge clk);
        #1 chk({done, acc, cf, pc}, {1'b0, acc_m, cf_m, pc_m});
    endtask : run
    // Two-byte add chain and carry boundaries.
    task automatic t_add();
        load(1'b0, 16'h003a);
        run(8'hf4, 8'he0);
        load(1'b0, 16'h0091);
        run(8'h74, 8'hfb);
        run(8'hf4, 8'h00);
        run(8'hfc, 8'h73);
        run(8'h7c, 8'hff);
        run(8'h74, 8'h00);
    endtask : t_add
    // Two-byte reverse subtract chain, then every subtract form both ways.
    task automatic t_sub();
        logic [7:0] ops [8] = '{8'hf7, 8'hff, 8'h77, 8'h7f, 8'h7d, 8'hfd, 8'h75, 8'hf5};
        load(1'b0, 16'h0092);
        run(8'hf5, 8'h79);
        load(1'b0, 16'h00fa);
        run(8'h75, 8'h81);
        foreach (ops[i]) begin
            run(ops[i], 8'h40);
            run(ops[i], 8'hc1);
        end
    endtask : t_sub
    // Skips with the flag set and clear; others leave acc and flag alone.
    task automatic t_skip();
        load(1'b1, 16'hfff0);
        run(8'h38, 8'h55);
        run(8'hc8, 8'h55);
        load(1'b0, 16'h00ff);
        run(8'hfc, 8'h01);
        run(8'hcf, 8'h00);
        run(8'h00, 8'h00);
        run(8'hf4, 8'h00);
        run(8'hcf, 8'h00);
        run(8'h71, 8'h9c);
    endtask : t_skip
    // Watchdog well beyond the roughly 120 cycles the tests take.
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        #1 chk({done, acc, cf, pc}, 26'h0000000);
        t_add();
        t_sub();
        t_skip();
        end_sim();
    end
endmodule : carry_flag_arith_and_skip_test
